/* File: evlp_pkg.sv */
// Package for the encoder velocity and closed-loop parameter bank.
// Assumes a 32-bit Wishbone word bus; register indices are word indices.
package evlp_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_ERROR_DEADBAND = 8'h5F;
	localparam logic [7:0] IDX_BACKEMF_START = 8'h60;
	localparam logic [7:0] IDX_BACKEMF_ADDED = 8'h61;
	localparam logic [7:0] IDX_VEL_ZERO_TIMEOUT = 8'h62;
	localparam logic [7:0] IDX_VEL_FILTER_CFG = 8'h63;
	localparam logic [7:0] IDX_MODE_CONTROL = 8'h64;
	localparam logic [7:0] IDX_RAW_VELOCITY = 8'h65;
	localparam logic [7:0] IDX_MEAN_VELOCITY = 8'h66;
	localparam logic [7:0] IDX_ENCODER_RES = 8'h67;

	// Reset values
	localparam logic [31:0] RST_ERROR_DEADBAND = 32'h0000_0000;
	localparam logic [23:0] RST_BACKEMF_START = 24'h00_0000;
	localparam logic [31:0] RST_BACKEMF_ADDED = 32'h0000_0000;
	localparam logic [31:0] RST_VEL_ZERO_TIMEOUT = 32'h000F_FFFF;
	localparam logic [31:0] RST_VEL_FILTER_CFG = 32'h0000_0000;
	localparam logic [3:0] RST_MODE_CONTROL = 4'h0;
	localparam logic [31:0] RST_ENCODER_RES = 32'h0000_0000;

	// Field positions
	localparam int POS_DB_MSB = 19;
	localparam int GAIN_DB_MSB = 7;
	localparam int SAMPLE_DELAY_MSB = 7;
	localparam int FILTER_EXP_LSB = 8;
	localparam int FILTER_EXP_MSB = 11;
	localparam int INTERVAL_LSB = 16;
	localparam int INTERVAL_MSB = 31;
	localparam int MODE_CLOSED_LOOP = 0;
	localparam int MODE_STALL = 1;
	localparam int MODE_ENC_LSB = 2;
	localparam int MODE_ENC_MSB = 3;

	// Fixed figures
	localparam logic [31:0] UNITY_GAIN = 32'h0001_0000;
	localparam logic [15:0] MIN_UPDATE_INTERVAL = 16'h0100;
	localparam int JUMP_FRACTION_SHIFT = 3;
	localparam int JUMP_MULT_SHIFT = 8;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ENC_QUADRATURE,
		ENC_SSI,
		ENC_SPI,
		ENC_RESERVED
	} evlp_enc_t;

	typedef enum logic {
		DIV_IDLE,
		DIV_RUN
	} evlp_div_t;
endpackage : evlp_pkg

/* File: evlp_core.sv */
// Encoder velocity and closed-loop parameter bank with Wishbone slave.
// Assumes quadrature pins are asynchronous; absolute samples and
// loop inputs arrive on i_ref_clk from neighbouring logic.
// Function
// - Zero the PID position error while its magnitude is below the deadband.
// - Hold position gain at unity while deviation magnitude is below gain deadband.
// - In closed loop, start back-EMF compensation once encoder velocity reaches the start velocity.
// - Start velocity register doubles as stall mode minimum velocity when enabled.
// - Same register is the fullstep switch velocity without stall or closed loop.
// - Add the additional velocity to encoder velocity for maximum angle.
// - Additional velocity register is a stall mode configuration word when active.
// - Clear mean velocity after timeout cycles with no incremental change.
// - Wait the programmed sample delay between two mean velocity samples.
// - Serial encoders use the serial request period as sample delay.
// - Limit absolute jumps to multiplier/256 times one eighth of resolution.
// - A zero multiplier allows jumps up to one eighth of resolution.
// - The filter exponent field sets mean velocity smoothing strength.
// - Incremental velocity updates every interval cycles, at least 256.
// - Absolute encoders run the control cycle at the programmed period.
// - Quadrature encoders run the control cycle at the fastest rate.
// - Raw encoder velocity reads as signed 32-bit pulses per second.
// - Mean encoder velocity reads as signed 32-bit pulses per second.
//
// The implementer's own choice: register access over Wishbone.
module evlp_core
	import evlp_pkg::*;
#(
	parameter int ADR_W = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [ADR_W+1:2] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_enc_a,
	input wire logic i_enc_b,
	input wire logic i_abs_valid,
	input wire logic [31:0] i_abs_position,
	input wire logic [15:0] i_serial_request_period,
	input wire logic signed [31:0] i_pid_position_error,
	input wire logic signed [31:0] i_encoder_position_deviation,
	input wire logic [31:0] i_position_gain,
	output logic signed [31:0] o_pid_position_error,
	output logic [31:0] o_position_gain,
	output logic o_backemf_active,
	output logic [31:0] o_backemf_velocity_sum,
	output logic [23:0] o_stall_mode_min_velocity,
	output logic [23:0] o_fullstep_switch_velocity,
	output logic [31:0] o_stall_mode_config,
	output logic o_control_tick,
	output logic o_abs_jump_error
);
	if (ADR_W < 7) begin : g_adr_check
		$error("ADR_W too small for the register indices");
	end

	function automatic logic [31:0] mag(input logic signed [31:0] v);
		mag = v[31] ? 32'(-v) : 32'(v);
	endfunction : mag

	// Wishbone slave: one wait state, registered ack
	logic ack_q;
	logic [31:0] rdat_q;
	logic [31:0] error_deadband_q;
	logic [23:0] backemf_start_velocity_q;
	logic [31:0] backemf_added_velocity_q;
	logic [31:0] velocity_zero_timeout_q;
	logic [31:0] velocity_filter_config_q;
	logic [3:0] mode_control_q;
	logic [31:0] encoder_resolution_q;
	logic signed [31:0] raw_velocity_q;
	logic signed [31:0] mean_velocity_q;
	logic [7:0] idx;
	logic wr_en;

	assign idx = 8'(i_wb_adr);
	// Write commits on the edge where the master sees ack
	assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && ack_q;
	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		for (int b = 0; b < 4; b++) begin
			merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction : merge

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= i_wb_cyc && i_wb_stb && !ack_q;
			rdat_q <= 32'h0000_0000;
			if (i_wb_cyc && i_wb_stb && !i_wb_we && !ack_q) begin
				case (idx)
					IDX_MODE_CONTROL: rdat_q <= {28'h000_0000, mode_control_q};
					IDX_RAW_VELOCITY: rdat_q <= raw_velocity_q;
					IDX_MEAN_VELOCITY: rdat_q <= mean_velocity_q;
					IDX_ENCODER_RES: rdat_q <= encoder_resolution_q;
					default: rdat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			error_deadband_q <= RST_ERROR_DEADBAND;
			backemf_start_velocity_q <= RST_BACKEMF_START;
			backemf_added_velocity_q <= RST_BACKEMF_ADDED;
			velocity_zero_timeout_q <= RST_VEL_ZERO_TIMEOUT;
			velocity_filter_config_q <= RST_VEL_FILTER_CFG;
			mode_control_q <= RST_MODE_CONTROL;
			encoder_resolution_q <= RST_ENCODER_RES;
		end else if (wr_en) begin
			case (idx)
				IDX_ERROR_DEADBAND:
					error_deadband_q <= merge(error_deadband_q, i_wb_dat, i_wb_sel);
				IDX_BACKEMF_START:
					backemf_start_velocity_q <= 24'(merge({8'h00, backemf_start_velocity_q},
						i_wb_dat, i_wb_sel));
				IDX_BACKEMF_ADDED:
					backemf_added_velocity_q <= merge(backemf_added_velocity_q, i_wb_dat,
						i_wb_sel);
				IDX_VEL_ZERO_TIMEOUT:
					velocity_zero_timeout_q <= merge(velocity_zero_timeout_q, i_wb_dat,
						i_wb_sel);
				IDX_VEL_FILTER_CFG:
					velocity_filter_config_q <= merge(velocity_filter_config_q, i_wb_dat,
						i_wb_sel);
				IDX_MODE_CONTROL:
					mode_control_q <= 4'(merge({28'h000_0000, mode_control_q}, i_wb_dat,
						i_wb_sel));
				IDX_ENCODER_RES:
					encoder_resolution_q <= merge(encoder_resolution_q, i_wb_dat, i_wb_sel);
				default: ;
			endcase
		end
	end

	// Field views
	logic closed_loop_en;
	logic stall_en;
	evlp_enc_t enc_type;
	logic is_serial;
	logic [7:0] sample_delay_field;
	logic [3:0] filter_exp;
	logic [15:0] interval_field;
	logic [15:0] update_interval;
	assign closed_loop_en = mode_control_q[MODE_CLOSED_LOOP];
	assign stall_en = mode_control_q[MODE_STALL];
	assign enc_type = evlp_enc_t'(mode_control_q[MODE_ENC_MSB:MODE_ENC_LSB]);
	assign is_serial = (enc_type == ENC_SSI) || (enc_type == ENC_SPI);
	assign sample_delay_field = velocity_filter_config_q[SAMPLE_DELAY_MSB:0];
	assign filter_exp = velocity_filter_config_q[FILTER_EXP_MSB:FILTER_EXP_LSB];
	assign interval_field = velocity_filter_config_q[INTERVAL_MSB:INTERVAL_LSB];
	assign update_interval = (interval_field < MIN_UPDATE_INTERVAL) ?
		MIN_UPDATE_INTERVAL : interval_field;

	// Loop outputs
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pid_position_error <= 32'sh0000_0000;
			o_position_gain <= UNITY_GAIN;
			o_backemf_active <= 1'b0;
			o_backemf_velocity_sum <= 32'h0000_0000;
			o_stall_mode_min_velocity <= 24'h00_0000;
			o_fullstep_switch_velocity <= 24'h00_0000;
			o_stall_mode_config <= 32'h0000_0000;
		end else begin
			o_pid_position_error <= (mag(i_pid_position_error) <
				{12'h000, error_deadband_q[POS_DB_MSB:0]}) ? 32'sh0 : i_pid_position_error;
			o_position_gain <= (mag(i_encoder_position_deviation) <
				{24'h00_0000, error_deadband_q[GAIN_DB_MSB:0]}) ? UNITY_GAIN : i_position_gain;
			o_backemf_active <= closed_loop_en &&
				(mag(raw_velocity_q) >= {8'h00, backemf_start_velocity_q});
			o_backemf_velocity_sum <= mag(raw_velocity_q) +
				{8'h00, backemf_added_velocity_q[23:0]};
			o_stall_mode_min_velocity <= stall_en ? backemf_start_velocity_q : 24'h00_0000;
			o_fullstep_switch_velocity <= (!stall_en && !closed_loop_en) ?
				backemf_start_velocity_q : 24'h00_0000;
			o_stall_mode_config <= stall_en ? backemf_added_velocity_q : 32'h0000_0000;
		end
	end

	// Quadrature input: two-stage synchroniser, then decode
	logic [1:0] ab_meta_q;
	logic [1:0] ab_sync_q;
	logic [1:0] ab_prev_q;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ab_meta_q <= 2'h0;
			ab_sync_q <= 2'h0;
			ab_prev_q <= 2'h0;
		end else begin
			ab_meta_q <= {i_enc_a, i_enc_b};
			ab_sync_q <= ab_meta_q;
			ab_prev_q <= ab_sync_q;
		end
	end

	function automatic logic signed [1:0] quad_step(input logic [1:0] p, input logic [1:0] c);
		case ({p, c})
			4'h1, 4'h7, 4'hE, 4'h8: quad_step = 2'sb01;
			4'h2, 4'hB, 4'hD, 4'h4: quad_step = 2'sb11;
			default: quad_step = 2'sb00;
		endcase
	endfunction : quad_step

	logic signed [1:0] step;
	logic is_quad;
	assign step = quad_step(ab_prev_q, ab_sync_q);
	assign is_quad = (enc_type == ENC_QUADRATURE);

	// Velocity source: pulse count per interval or absolute delta per period
	logic signed [31:0] pulse_count_q;
	logic [15:0] interval_cnt_q;
	logic [31:0] last_abs_q;
	logic abs_seen_q;
	logic div_start;
	logic signed [31:0] div_num;
	logic [15:0] div_den;
	logic interval_done;
	logic signed [31:0] abs_delta;
	logic [31:0] jump_base;
	logic [31:0] jump_limit;
	logic abs_ok;
	logic [15:0] loop_period;

	assign interval_done = is_quad && (interval_cnt_q >= update_interval - 16'h0001);
	assign abs_delta = $signed(i_abs_position - last_abs_q);
	assign jump_base = encoder_resolution_q >> JUMP_FRACTION_SHIFT;
	assign jump_limit = (sample_delay_field == 8'h00) ? jump_base :
		32'(({8'h00, jump_base} * 40'(sample_delay_field)) >> JUMP_MULT_SHIFT);
	assign abs_ok = !abs_seen_q || (mag(abs_delta) <= jump_limit);
	assign loop_period = (interval_field == 16'h0000) ? 16'h0001 : interval_field;
	assign div_start = interval_done || (!is_quad && i_abs_valid && abs_ok && abs_seen_q);
	assign div_num = is_quad ? pulse_count_q + 32'(step) : abs_delta;
	assign div_den = is_quad ? update_interval : loop_period;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pulse_count_q <= 32'sh0;
			interval_cnt_q <= 16'h0000;
		end else if (interval_done || !is_quad) begin
			pulse_count_q <= 32'sh0;
			interval_cnt_q <= 16'h0000;
		end else begin
			pulse_count_q <= pulse_count_q + 32'(step);
			interval_cnt_q <= interval_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			last_abs_q <= 32'h0000_0000;
			abs_seen_q <= 1'b0;
			o_abs_jump_error <= 1'b0;
		end else begin
			o_abs_jump_error <= !is_quad && i_abs_valid && !abs_ok;
			if (!is_quad && i_abs_valid && abs_ok) begin
				last_abs_q <= i_abs_position;
				abs_seen_q <= 1'b1;
			end else if (is_quad) begin
				abs_seen_q <= 1'b0;
			end
		end
	end

	// Control tick: every cycle for quadrature, programmed period otherwise
	logic [15:0] loop_cnt_q;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			loop_cnt_q <= 16'h0000;
			o_control_tick <= 1'b0;
		end else if (is_quad) begin
			loop_cnt_q <= 16'h0000;
			o_control_tick <= 1'b1;
		end else if (loop_cnt_q >= loop_period - 16'h0001) begin
			loop_cnt_q <= 16'h0000;
			o_control_tick <= 1'b1;
		end else begin
			loop_cnt_q <= loop_cnt_q + 16'h0001;
			o_control_tick <= 1'b0;
		end
	end

	// Serial divider: |count| * CLK_HZ / cycles; a start while busy is dropped,
	// which costs one stale update but never a wrong one
	evlp_div_t div_state_q;
	logic [63:0] dividend_q;
	logic [16:0] rem_q;
	logic [15:0] den_q;
	logic neg_q;
	logic [6:0] bit_cnt_q;
	logic [16:0] rem_try;
	assign rem_try = {rem_q[15:0], dividend_q[63]};

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_state_q <= DIV_IDLE;
			dividend_q <= 64'h0;
			rem_q <= 17'h0;
			den_q <= 16'h0001;
			neg_q <= 1'b0;
			bit_cnt_q <= 7'h00;
			raw_velocity_q <= 32'sh0;
		end else begin
			case (div_state_q)
				DIV_IDLE: begin
					if (div_start) begin
						dividend_q <= 64'(mag(div_num)) * 64'(CLK_HZ);
						rem_q <= 17'h0;
						den_q <= div_den;
						neg_q <= div_num[31];
						bit_cnt_q <= 7'h40;
						div_state_q <= DIV_RUN;
					end
				end
				DIV_RUN: begin
					if (rem_try >= {1'b0, den_q}) begin
						rem_q <= rem_try - {1'b0, den_q};
						dividend_q <= {dividend_q[62:0], 1'b1};
					end else begin
						rem_q <= rem_try;
						dividend_q <= {dividend_q[62:0], 1'b0};
					end
					bit_cnt_q <= bit_cnt_q - 7'h01;
					if (bit_cnt_q == 7'h01) begin
						div_state_q <= DIV_IDLE;
						raw_velocity_q <= neg_q ? -$signed({dividend_q[30:0], rem_try >= {1'b0, den_q}})
							: $signed({dividend_q[30:0], rem_try >= {1'b0, den_q}});
					end
				end
				default: div_state_q <= DIV_IDLE;
			endcase
		end
	end

	// Mean filter sampling and zero timeout
	logic [15:0] sample_delay;
	logic [15:0] sample_cnt_q;
	logic [31:0] idle_cnt_q;
	logic sample_now;
	logic zero_now;
	logic signed [32:0] mean_diff;
	assign sample_delay = is_serial ? i_serial_request_period : {8'h00, sample_delay_field};
	assign sample_now = sample_cnt_q >= sample_delay;
	assign zero_now = is_quad && (idle_cnt_q >= velocity_zero_timeout_q);
	assign mean_diff = 33'(raw_velocity_q) - 33'(mean_velocity_q);

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sample_cnt_q <= 16'h0000;
			idle_cnt_q <= 32'h0000_0000;
			mean_velocity_q <= 32'sh0;
		end else begin
			sample_cnt_q <= sample_now ? 16'h0000 : sample_cnt_q + 16'h0001;
			if (step != 2'sb00 || !is_quad) begin
				idle_cnt_q <= 32'h0000_0000;
			end else if (!zero_now) begin
				idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
			end
			if (zero_now) begin
				mean_velocity_q <= 32'sh0;
			end else if (sample_now) begin
				mean_velocity_q <= mean_velocity_q + 32'(mean_diff >>> filter_exp);
			end
		end
	end

	// Checks
	unity_gain_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(mag(i_encoder_position_deviation) < {24'h0, error_deadband_q[7:0]})
		|=> (o_position_gain == UNITY_GAIN)) else $error("gain not held at unity");
	err_deadband_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(mag(i_pid_position_error) < {12'h0, error_deadband_q[19:0]})
		|=> (o_pid_position_error == 0)) else $error("error not zeroed in deadband");
	backemf_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_backemf_active |-> $past(closed_loop_en)) else $error("back-EMF without closed loop");
	stall_alias_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$past(stall_en) |-> o_stall_mode_min_velocity == $past(backemf_start_velocity_q))
		else $error("stall minimum velocity not aliased");
	fullstep_alias_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		($past(stall_en) || $past(closed_loop_en)) |-> o_fullstep_switch_velocity == 0)
		else $error("fullstep velocity active in wrong mode");
	zero_mean_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		zero_now |=> mean_velocity_q == 0) else $error("mean not cleared on timeout");
	min_interval_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		interval_done |-> interval_cnt_q >= 16'h00FF) else $error("interval below 256");
	quad_tick_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		is_quad ##1 is_quad ##1 is_quad |-> o_control_tick) else $error("quadrature tick missing");
	jump_reject_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(!is_quad && i_abs_valid && abs_seen_q && mag(abs_delta) > jump_limit)
		|=> o_abs_jump_error) else $error("jump not flagged");
	wb_ack_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack) else $error("ack late");
endmodule : evlp_core

/* File: evlp_enc_model.sv */
// Encoder model: quadrature pins stepping at a set rate, and absolute samples on request.
// Assumes the bench drives its controls on i_ref_clk; samples arrive one cycle after a request.
module evlp_enc_model (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [15:0] i_step_period,
	input wire logic i_dir,
	input wire logic i_abs_req,
	input wire logic [31:0] i_abs_pos,
	output logic o_enc_a,
	output logic o_enc_b,
	output logic o_abs_valid,
	output logic [31:0] o_abs_position
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt_q;
	logic [1:0] ph_q;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 16'h0000;
			ph_q <= 2'h0;
		end else if (i_step_period == 16'h0000) begin
			cnt_q <= 16'h0000;
		end else if (cnt_q >= i_step_period - 16'h0001) begin
			cnt_q <= 16'h0000;
			ph_q <= i_dir ? ph_q - 2'h1 : ph_q + 2'h1;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
	// Gray sequence so only one pin moves per step
	assign o_enc_a = ph_q[1];
	assign o_enc_b = ph_q[1] ^ ph_q[0];
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_abs_valid <= 1'b0;
			o_abs_position <= 32'h0000_0000;
		end else begin
			o_abs_valid <= i_abs_req;
			if (i_abs_req) begin
				o_abs_position <= i_abs_pos;
			end else if (o_abs_valid) begin
				// Stale data is scrambled so nothing leans on it
				o_abs_position <= ~o_abs_position;
			end
		end
	end
endmodule : evlp_enc_model

/* File: tb_encoder_velocity_loop_params.sv */
// Self-checking bench for the velocity parameter bank over classic Wishbone.
// Assumes the encoder model above on the far side; one 100 MHz clock.
module tb_encoder_velocity_loop_params;
	timeunit 1ns;
	timeprecision 1ns;
	import evlp_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic ack, enc_a, enc_b, abs_valid, bemf_act, tick, jump_err, dir = 1'b0, abs_req = 1'b0;
	logic [31:0] abs_position, abs_pos = 32'h0, gain_in = 32'h0002_0000, gain_out, bemf_sum, st_cfg;
	logic [15:0] step_period = 16'h0, ser_period = 16'h0032;
	logic signed [31:0] err_in = 32'sh0, dev_in = 32'sh0, err_out;
	logic [23:0] st_min, fullstep_switch_velocity;
	int miscompares = 0, n_compared = 0, n, seen;
	localparam logic signed [31:0] STEP_VEL = 32'sd390625;

	evlp_core u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_enc_a(enc_a), .i_enc_b(enc_b), .i_abs_valid(abs_valid),
		.i_abs_position(abs_position), .i_serial_request_period(ser_period),
		.i_pid_position_error(err_in), .i_encoder_position_deviation(dev_in),
		.i_position_gain(gain_in), .o_pid_position_error(err_out), .o_position_gain(gain_out),
		.o_backemf_active(bemf_act), .o_backemf_velocity_sum(bemf_sum),
		.o_stall_mode_min_velocity(st_min), .o_fullstep_switch_velocity(fullstep_switch_velocity),
		.o_stall_mode_config(st_cfg), .o_control_tick(tick), .o_abs_jump_error(jump_err));
	evlp_enc_model u_enc (.i_ref_clk(clk), .i_rst_n(rst_n), .i_step_period(step_period),
		.i_dir(dir), .i_abs_req(abs_req), .i_abs_pos(abs_pos), .o_enc_a(enc_a),
		.o_enc_b(enc_b), .o_abs_valid(abs_valid), .o_abs_position(abs_position));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic chk_rng(input string name, input logic signed [31:0] lo,
		input logic signed [31:0] hi, input logic signed [31:0] got);
		n_compared++;
		if ($isunknown(got) || got < lo || got > hi) begin
			miscompares++;
			$display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask : chk_rng

	// Holds the request until ack is sampled; releases at that edge
	task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= idx;
		wdat <= d;
		sel <= 4'hF;
		// No wait bound here: a missing ack is caught by the watchdog
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic wait_clk(input int c);
		repeat (c) @(posedge clk);
	endtask : wait_clk

	task automatic abs_send(input logic [31:0] pos, input logic exp_err);
		@(posedge clk);
		abs_req <= 1'b1;
		abs_pos <= pos;
		@(posedge clk);
		abs_req <= 1'b0;
		seen = 0;
		repeat (6) begin
			@(posedge clk);
			if (jump_err === 1'b1) seen = 1;
		end
		chk("abs_jump_error", {31'h0, exp_err}, seen);
		wait_clk(120);
	endtask : abs_send

	initial begin
		#(10 * 60000);
		miscompares++;
		$display("ERROR watchdog expected done seen hang");
		stop_test();
	end

	initial begin
		wait_clk(2);
		rst_n <= 1'b1;
		wait_clk(1);
		chk("gain_after_reset", UNITY_GAIN, gain_out);
		wb(1'b1, IDX_RAW_VELOCITY, 32'hFFFF_FFFF);
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, (i < 3) ? 8'h5F + i[7:0] : (i < 5) ? 8'h62 + i[7:0] : 8'h70, 32'h0);
			chk("reset_read", 32'h0, rd);
		end
		// Deadbands: position 0x105, gain 0x05
		wb(1'b1, IDX_ERROR_DEADBAND, 32'h0000_0105);
		err_in <= 32'sd260;
		dev_in <= 32'sd4;
		wait_clk(3);
		chk("pid_err_inside", 32'h0, err_out);
		chk("gain_inside", UNITY_GAIN, gain_out);
		err_in <= -32'sd261;
		dev_in <= -32'sd5;
		wait_clk(3);
		chk("pid_err_edge", -32'sd261, err_out);
		chk("gain_edge", gain_in, gain_out);
		// Shared start velocity register across modes
		wb(1'b1, IDX_BACKEMF_START, 32'hFF12_3456);
		wb(1'b1, IDX_BACKEMF_ADDED, 32'hA000_0010);
		wait_clk(3);
		chk("fullstep_vel", 32'h0012_3456, {8'h0, fullstep_switch_velocity});
		chk("stall_min_off", 32'h0, {8'h0, st_min});
		wb(1'b1, IDX_MODE_CONTROL, 32'h0000_0002);
		wait_clk(3);
		chk("stall_min_on", 32'h0012_3456, {8'h0, st_min});
		chk("stall_cfg", 32'hA000_0010, st_cfg);
		chk("fullstep_off", 32'h0, {8'h0, fullstep_switch_velocity});
		// Quadrature, closed loop; interval 16 is raised to 256
		wb(1'b1, IDX_MODE_CONTROL, 32'h0000_0001);
		wb(1'b1, IDX_VEL_FILTER_CFG, 32'h0010_0028);
		step_period <= 16'h0010;
		seen = 0;
		for (int i = 0; i < 700; i++) begin
			@(posedge clk);
			if (tick !== 1'b1) seen++;
		end
		chk("quad_tick_always", 32'h0, seen);
		wb(1'b0, IDX_RAW_VELOCITY, 32'h0);
		chk_rng("raw_vel_fwd", 16 * STEP_VEL - STEP_VEL, 16 * STEP_VEL + STEP_VEL, rd);
		wb(1'b0, IDX_MEAN_VELOCITY, 32'h0);
		chk_rng("mean_vel", 16 * STEP_VEL - STEP_VEL, 16 * STEP_VEL + STEP_VEL, rd);
		chk("bemf_active", 32'h1, {31'h0, bemf_act});
		dir <= 1'b1;
		wait_clk(700);
		wb(1'b0, IDX_RAW_VELOCITY, 32'h0);
		chk_rng("raw_vel_rev", -17 * STEP_VEL, -15 * STEP_VEL, rd);
		chk_rng("bemf_sum", 15 * STEP_VEL + 16, 17 * STEP_VEL + 16, bemf_sum);
		wb(1'b1, IDX_BACKEMF_START, 32'h00FF_FFFF);
		wait_clk(3);
		chk("bemf_below", 32'h0, {31'h0, bemf_act});
		// Steps stop; mean clears after the timeout
		wb(1'b1, IDX_VEL_ZERO_TIMEOUT, 32'h0000_0064);
		step_period <= 16'h0000;
		wait_clk(400);
		wb(1'b0, IDX_MEAN_VELOCITY, 32'h0);
		chk("mean_timeout", 32'h0, rd);
		// Serial absolute encoder, loop period 100, resolution 2048
		wb(1'b1, IDX_ENCODER_RES, 32'h0000_0800);
		wb(1'b1, IDX_VEL_FILTER_CFG, 32'h0064_0000);
		wb(1'b1, IDX_MODE_CONTROL, 32'h0000_0005);
		// Let the stale quadrature tick drain before timing the period
		wait_clk(3);
		n = 0;
		while (tick !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tick !== 1'b1 && n < 300);
		chk("loop_period", 32'd100, n);
		abs_send(32'd1000, 1'b0);
		abs_send(32'd1256, 1'b0);
		wb(1'b0, IDX_RAW_VELOCITY, 32'h0);
		chk("abs_raw_vel", 32'h0F42_4000, rd);
		wb(1'b0, IDX_MEAN_VELOCITY, 32'h0);
		chk("abs_mean_vel", 32'h0F42_4000, rd);
		abs_send(32'd1513, 1'b1);
		wb(1'b1, IDX_VEL_FILTER_CFG, 32'h0064_0080);
		abs_send(32'd1385, 1'b1);
		abs_send(32'd1384, 1'b0);
		stop_test();
	end
endmodule : tb_encoder_velocity_loop_params
